/* File: core/adm_axis_mode.sv */
// Operation
// - each axis has its own drive-mode copy; writes go to selected axis
// - mode bit 0 selects automatic, 1 manual deceleration
// - separate-rate 0 uses acceleration for both ramps, 1 uses decel
// - profile bit 0 trapezoid, 1 S-curve; host loads jerk first
// - jog field: off, continuous, fixed move, handwheel
// - continuous jog emits pulses while jog input is low
// - fixed jog starts move on high-to-low jog input edge
// - handwheel: plus rise or fall while minus low starts moves
// - triangle-avoid bit enables triangle prevention on fixed moves
// - wrap bit makes both position counters ring counters
// - output select: 0 general outputs, 1 drive status outputs
// - status outputs 0 and 1 show jerk rising and falling
// - outputs 2 and 3 show upper and lower compare results
// - status output 4 high while drive pulses are emitted
// - outputs 5 to 7 show accelerate, constant, decelerate
// - home search deviation clear overrides output 0
// - five filter enables route groups through filter or bypass
// - shared emergency filter enable comes from first axis only
// - three-bit time constant selects eight filter delays
// - output register low byte first axis, high byte second
// - drive-mode registers clear to zero on reset
// - output register clears to zero, pins low on reset
// - compare source bit picks logical or real counter
`timescale 1ns/1ps
module adm_axis_mode
  import adm_pkg::*;
#(
  parameter int FLT_SHORT_CYC = ADM_FLT_SHORT_CYC,
  parameter int FLT_BASE_CYC  = ADM_FLT_BASE_CYC
)
(
  // clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // axi4-lite write
  input  wire logic [7:0]              awaddr,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  // axi4-lite read
  input  wire logic [7:0]              araddr,
  input  wire logic                    arvalid,
  output logic                         arready,
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready,
  // raw input pins, index 0 first axis
  input  wire logic                    emergency_stop_input,
  input  wire logic [1:0]              plus_limit_input,
  input  wire logic [1:0]              minus_limit_input,
  input  wire logic [1:0][1:0]         decel_stop_inputs,
  input  wire logic [1:0]              index_stop_input,
  input  wire logic [1:0]              in_position_input,
  input  wire logic [1:0]              servo_alarm_input,
  input  wire logic [1:0]              jog_plus_input,
  input  wire logic [1:0]              jog_minus_input,
  input  wire logic [1:0][5:0]         general_inputs,
  // drive status from pulse generator
  input  wire logic [1:0]              jerk_rising_flag,
  input  wire logic [1:0]              jerk_falling_flag,
  input  wire logic [1:0]              drive_active,
  input  wire logic [1:0]              accelerating_flag,
  input  wire logic [1:0]              constant_speed_flag,
  input  wire logic [1:0]              decelerating_flag,
  input  wire logic [1:0]              home_dcc_active,
  input  wire logic [1:0]              deviation_clear_output,
  // position counters and compare values
  input  wire logic [1:0][31:0]        logical_position,
  input  wire logic [1:0][31:0]        real_position,
  input  wire logic [1:0][31:0]        upper_compare,
  input  wire logic [1:0][31:0]        lower_compare,
  // ramp rates
  input  wire logic [1:0][15:0]        accel_rate,
  input  wire logic [1:0][15:0]        decel_rate,
  output logic [1:0][15:0]             ramp_rate,
  // mode outputs to the pulse generator
  output logic [1:0]                   manual_decel_select,
  output logic [1:0]                   separate_decel_rate_enable,
  output logic [1:0]                   scurve_profile_select,
  output logic [1:0]                   triangle_avoid_enable,
  output logic [1:0]                   counter_wrap_enable,
  // jog drive requests
  output logic [1:0]                   jog_cont_plus,
  output logic [1:0]                   jog_cont_minus,
  output logic [1:0]                   jog_start_plus,
  output logic [1:0]                   jog_start_minus,
  // filtered inputs
  output logic                         emergency_filtered,
  output logic [1:0][ADM_IN_NUM-1:0]   filtered_inputs,
  // output pins
  output logic [1:0][7:0]              axis_output_pins
);

  logic [1:0][15:0]           mode_r;
  logic [1:0][15:0]           mode_nxt;
  logic [15:0]                gpo_r;
  logic [15:0]                gpo_nxt;
  logic                       sel_r;
  logic                       sel_nxt;
  logic [1:0]                 cmp_src_r;
  logic [1:0]                 cmp_src_nxt;
  logic                       bvalid_r;
  logic                       bvalid_nxt;
  logic [1:0]                 bresp_r;
  logic [1:0]                 bresp_nxt;
  logic                       rvalid_r;
  logic                       rvalid_nxt;
  logic [1:0]                 rresp_r;
  logic [1:0]                 rresp_nxt;
  logic [31:0]                rdata_r;
  logic [31:0]                rdata_nxt;
  logic                       wr_go;
  logic                       rd_go;
  logic [1:0][7:0]            pins_r;
  logic [1:0][7:0]            pins_nxt;
  logic [1:0][15:0]           rate_r;
  logic [1:0][15:0]           rate_nxt;
  logic [1:0][ADM_IN_NUM-1:0] raw_in;
  logic [1:0][ADM_IN_NUM-1:0] flt_en;

  // --------------------
  // bus handshake
  // --------------------
  assign wr_go   = awvalid & wvalid & ~bvalid_r;
  assign rd_go   = arvalid & ~rvalid_r;
  assign awready = wr_go;
  assign wready  = wr_go;
  assign arready = rd_go;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign rvalid  = rvalid_r;
  assign rresp   = rresp_r;
  assign rdata   = rdata_r;

  // --------------------
  // register writes and reads
  // --------------------
  always_comb
  begin
    mode_nxt    = mode_r;
    gpo_nxt     = gpo_r;
    sel_nxt     = sel_r;
    cmp_src_nxt = cmp_src_r;
    bvalid_nxt  = bvalid_r & ~bready;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r & ~rready;
    rresp_nxt   = rresp_r;
    rdata_nxt   = rdata_r;
    if (wr_go)
    begin
      bvalid_nxt = 1'b1;
      bresp_nxt  = ADM_RESP_OK;
      case (awaddr)
        ADM_OFS_AXIS_SEL:
          if (wstrb[0])
            sel_nxt = wdata[0];
        ADM_OFS_MODE3:
        begin
          if (wstrb[0])
            mode_nxt[sel_r][7:0] = wdata[7:0];
          if (wstrb[1])
            mode_nxt[sel_r][15:8] = wdata[15:8];
        end
        ADM_OFS_GPO:
        begin
          if (wstrb[0])
            gpo_nxt[7:0] = wdata[7:0];
          if (wstrb[1])
            gpo_nxt[15:8] = wdata[15:8];
        end
        ADM_OFS_CMP_SRC:
          if (wstrb[0])
            cmp_src_nxt = wdata[1:0];
        default:
          bresp_nxt = ADM_RESP_ERR;
      endcase
    end
    if (rd_go)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = ADM_RESP_OK;
      case (araddr)
        ADM_OFS_AXIS_SEL:
          rdata_nxt = {31'h0, sel_r};
        ADM_OFS_MODE3:
          rdata_nxt = {16'h0, mode_r[sel_r]};
        ADM_OFS_GPO:
          rdata_nxt = {16'h0, gpo_r};
        ADM_OFS_CMP_SRC:
          rdata_nxt = {30'h0, cmp_src_r};
        ADM_OFS_STATUS:
          rdata_nxt = {6'h0, jog_cont_minus[sel_r], jog_cont_plus[sel_r],
                       axis_output_pins[sel_r], emergency_filtered,
                       filtered_inputs[sel_r]};
        default:
        begin
          rdata_nxt = 32'h0;
          rresp_nxt = ADM_RESP_ERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_r    <= {2{ADM_MODE3_RST}};
      gpo_r     <= ADM_GPO_RST;
      sel_r     <= 1'b0;
      cmp_src_r <= 2'b00;
      bvalid_r  <= 1'b0;
      bresp_r   <= ADM_RESP_OK;
      rvalid_r  <= 1'b0;
      rresp_r   <= ADM_RESP_OK;
      rdata_r   <= 32'h0;
    end
    else
    begin
      mode_r    <= mode_nxt;
      gpo_r     <= gpo_nxt;
      sel_r     <= sel_nxt;
      cmp_src_r <= cmp_src_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // --------------------
  // input filters and jog decode
  // --------------------
  adm_in_filter #(
    .SHORT_CYC (FLT_SHORT_CYC),
    .BASE_CYC  (FLT_BASE_CYC)
  ) u_emg_flt (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin       (emergency_stop_input),
    .enable    (mode_r[0][ADM_B_FE_LO + ADM_FE_LIMITS]),
    .time_code (mode_r[0][ADM_B_FL_LO +: 3]),
    .level     (emergency_filtered)
  );

  for (genvar a = 0; a < 2; a++)
  begin : g_axis
    assign raw_in[a] = {general_inputs[a], jog_minus_input[a],
                        jog_plus_input[a], servo_alarm_input[a],
                        in_position_input[a], index_stop_input[a],
                        decel_stop_inputs[a], minus_limit_input[a],
                        plus_limit_input[a]};
    for (genvar k = 0; k < ADM_IN_NUM; k++)
    begin : g_in
      localparam int GRP = (k >= ADM_IN_GP_LO) ? ADM_FE_GPIN :
                           (k >= ADM_IN_JOG_P) ? ADM_FE_JOG :
                           (k >= ADM_IN_INPOS) ? ADM_FE_SERVO :
                           (k == ADM_IN_STOP2) ? ADM_FE_STOP2 :
                           ADM_FE_LIMITS;
      assign flt_en[a][k] = mode_r[a][ADM_B_FE_LO + GRP];
      adm_in_filter #(
        .SHORT_CYC (FLT_SHORT_CYC),
        .BASE_CYC  (FLT_BASE_CYC)
      ) u_flt (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .pin       (raw_in[a][k]),
        .enable    (flt_en[a][k]),
        .time_code (mode_r[a][ADM_B_FL_LO +: 3]),
        .level     (filtered_inputs[a][k])
      );
    end
    adm_jog_decode u_jog (
      .aclk              (aclk),
      .aresetn           (aresetn),
      .external_jog_mode (mode_r[a][ADM_B_JOG_LO +: 2]),
      .jog_plus          (filtered_inputs[a][ADM_IN_JOG_P]),
      .jog_minus         (filtered_inputs[a][ADM_IN_JOG_M]),
      .cont_plus         (jog_cont_plus[a]),
      .cont_minus        (jog_cont_minus[a]),
      .start_plus        (jog_start_plus[a]),
      .start_minus       (jog_start_minus[a])
    );
    assign manual_decel_select[a]        = mode_r[a][ADM_B_MANUAL_DECEL_SELECT];
    assign separate_decel_rate_enable[a] = mode_r[a][ADM_B_SEPDEC];
    assign scurve_profile_select[a]      = mode_r[a][ADM_B_SCURVE];
    assign triangle_avoid_enable[a]      = mode_r[a][ADM_B_TRIANGLE_AVOID_ENABLE];
    assign counter_wrap_enable[a]        = mode_r[a][ADM_B_WRAP];
  end

  // --------------------
  // output pins and ramp rate
  // --------------------
  always_comb
  begin
    pins_nxt = pins_r;
    rate_nxt = rate_r;
    for (int a = 0; a < 2; a++)
    begin
      logic [31:0] pos;
      logic [7:0]  stat;
      pos  = cmp_src_r[a] ? real_position[a] : logical_position[a];
      stat = {decelerating_flag[a], constant_speed_flag[a],
              accelerating_flag[a], drive_active[a],
              $signed(pos) < $signed(lower_compare[a]),
              $signed(pos) >= $signed(upper_compare[a]),
              jerk_falling_flag[a], jerk_rising_flag[a]};
      if (mode_r[a][ADM_B_OUTSEL])
        pins_nxt[a] = stat;
      else
        pins_nxt[a] = gpo_r[8*a +: 8];
      if (home_dcc_active[a])
        pins_nxt[a][0] = deviation_clear_output[a];
      if (mode_r[a][ADM_B_SEPDEC] && decelerating_flag[a])
        rate_nxt[a] = decel_rate[a];
      else
        rate_nxt[a] = accel_rate[a];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pins_r <= {ADM_GPO_RST};
      rate_r <= '0;
    end
    else
    begin
      pins_r <= pins_nxt;
      rate_r <= rate_nxt;
    end
  end

  assign axis_output_pins = pins_r;
  assign ramp_rate        = rate_r;

endmodule

/* File: core/adm_pkg.sv */
package adm_pkg;

  // --------------------
  // register byte offsets
  // --------------------
  localparam logic [7:0] ADM_OFS_AXIS_SEL = 8'h00;
  localparam logic [7:0] ADM_OFS_MODE3    = 8'h04;
  localparam logic [7:0] ADM_OFS_GPO      = 8'h08;
  localparam logic [7:0] ADM_OFS_CMP_SRC  = 8'h0c;
  localparam logic [7:0] ADM_OFS_STATUS   = 8'h10;

  // --------------------
  // drive-mode field positions
  // --------------------
  localparam int ADM_B_MANUAL_DECEL_SELECT  = 0;
  localparam int ADM_B_SEPDEC = 1;
  localparam int ADM_B_SCURVE = 2;
  localparam int ADM_B_JOG_LO = 3;
  localparam int ADM_B_TRIANGLE_AVOID_ENABLE  = 5;
  localparam int ADM_B_WRAP   = 6;
  localparam int ADM_B_OUTSEL = 7;
  localparam int ADM_B_FE_LO  = 8;
  localparam int ADM_B_FL_LO  = 13;

  // filter enable groups
  localparam int ADM_FE_LIMITS = 0;
  localparam int ADM_FE_STOP2  = 1;
  localparam int ADM_FE_SERVO  = 2;
  localparam int ADM_FE_JOG    = 3;
  localparam int ADM_FE_GPIN   = 4;

  // per-axis filtered input index
  localparam int ADM_IN_LIM_P  = 0;
  localparam int ADM_IN_LIM_M  = 1;
  localparam int ADM_IN_STOP0  = 2;
  localparam int ADM_IN_STOP1  = 3;
  localparam int ADM_IN_STOP2  = 4;
  localparam int ADM_IN_INPOS  = 5;
  localparam int ADM_IN_ALARM  = 6;
  localparam int ADM_IN_JOG_P  = 7;
  localparam int ADM_IN_JOG_M  = 8;
  localparam int ADM_IN_GP_LO  = 9;
  localparam int ADM_IN_NUM    = 15;

  // jog mode codes
  localparam logic [1:0] ADM_JOG_OFF   = 2'b00;
  localparam logic [1:0] ADM_JOG_CONT  = 2'b01;
  localparam logic [1:0] ADM_JOG_FIXED = 2'b10;
  localparam logic [1:0] ADM_JOG_WHEEL = 2'b11;

  // --------------------
  // reset values and responses
  // --------------------
  localparam logic [15:0] ADM_MODE3_RST = 16'h0000;
  localparam logic [15:0] ADM_GPO_RST   = 16'h0000;
  localparam logic        ADM_PIN_IDLE  = 1'b1;
  localparam logic [1:0]  ADM_RESP_OK   = 2'b00;
  localparam logic [1:0]  ADM_RESP_ERR  = 2'b10;

  // --------------------
  // filter timing
  // --------------------
  localparam int ADM_CLK_NS       = 10;
  localparam int ADM_FLT_SHORT_NS = 2000;
  localparam int ADM_FLT_BASE_NS  = 256000;
  localparam int ADM_FLT_SHORT_CYC = ADM_FLT_SHORT_NS / ADM_CLK_NS;
  localparam int ADM_FLT_BASE_CYC  = ADM_FLT_BASE_NS / ADM_CLK_NS;
  localparam int ADM_FLT_CNT_W     = 21;

endpackage

/* File: core/adm_in_filter.sv */
`timescale 1ns/1ps
module adm_in_filter
  import adm_pkg::*;
#(
  parameter int SHORT_CYC = ADM_FLT_SHORT_CYC,
  parameter int BASE_CYC  = ADM_FLT_BASE_CYC
)
(
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // pin side
  input  wire logic       pin,
  input  wire logic       enable,
  input  wire logic [2:0] time_code,
  // filtered level
  output logic            level
);

  logic [2:0]               sync_r;
  logic [2:0]               sync_nxt;
  logic [ADM_FLT_CNT_W-1:0] cnt_r;
  logic [ADM_FLT_CNT_W-1:0] cnt_nxt;
  logic [ADM_FLT_CNT_W-1:0] limit;
  logic                     lvl_r;
  logic                     lvl_nxt;
  logic                     stable;

  assign level = lvl_r;

  // --------------------
  // stability counter
  // --------------------
  always_comb
  begin
    sync_nxt = {sync_r[1:0], pin};
    stable   = (sync_r[1] == sync_r[2]);
    if (time_code == 3'h0)
      limit = ADM_FLT_CNT_W'(SHORT_CYC);
    else
      limit = ADM_FLT_CNT_W'(BASE_CYC) << (time_code - 3'h1);
    cnt_nxt = cnt_r;
    lvl_nxt = lvl_r;
    if (!enable)
    begin
      cnt_nxt = '0;
      if (stable)
        lvl_nxt = sync_r[2];
    end
    else if (!stable || sync_r[2] == lvl_r)
      cnt_nxt = '0;
    else if (cnt_r >= limit - ADM_FLT_CNT_W'(1))
    begin
      lvl_nxt = sync_r[2];
      cnt_nxt = '0;
    end
    else
      cnt_nxt = cnt_r + ADM_FLT_CNT_W'(1);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync_r <= {3{ADM_PIN_IDLE}};
      cnt_r  <= '0;
      lvl_r  <= ADM_PIN_IDLE;
    end
    else
    begin
      sync_r <= sync_nxt;
      cnt_r  <= cnt_nxt;
      lvl_r  <= lvl_nxt;
    end
  end

endmodule

/* File: core/adm_jog_decode.sv */
`timescale 1ns/1ps
module adm_jog_decode
  import adm_pkg::*;
(
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // filtered jog levels and mode
  input  wire logic [1:0] external_jog_mode,
  input  wire logic       jog_plus,
  input  wire logic       jog_minus,
  // drive requests
  output logic            cont_plus,
  output logic            cont_minus,
  output logic            start_plus,
  output logic            start_minus
);

  logic       plus_d_r;
  logic       minus_d_r;
  logic [3:0] req_r;
  logic [3:0] req_nxt;
  logic       plus_fall;
  logic       plus_rise;
  logic       minus_fall;

  assign cont_plus   = req_r[0];
  assign cont_minus  = req_r[1];
  assign start_plus  = req_r[2];
  assign start_minus = req_r[3];

  // --------------------
  // mode decode
  // --------------------
  always_comb
  begin
    plus_fall  = plus_d_r & ~jog_plus;
    plus_rise  = ~plus_d_r & jog_plus;
    minus_fall = minus_d_r & ~jog_minus;
    req_nxt    = 4'h0;
    case (external_jog_mode)
      ADM_JOG_OFF:
        req_nxt = 4'h0;
      ADM_JOG_CONT:
      begin
        req_nxt[0] = ~jog_plus;
        req_nxt[1] = ~jog_minus;
      end
      ADM_JOG_FIXED:
      begin
        req_nxt[2] = plus_fall;
        req_nxt[3] = minus_fall;
      end
      ADM_JOG_WHEEL:
      begin
        req_nxt[2] = plus_rise & ~jog_minus;
        req_nxt[3] = plus_fall & ~jog_minus;
      end
      default:
        req_nxt = 4'h0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      plus_d_r  <= ADM_PIN_IDLE;
      minus_d_r <= ADM_PIN_IDLE;
      req_r     <= 4'h0;
    end
    else
    begin
      plus_d_r  <= jog_plus;
      minus_d_r <= jog_minus;
      req_r     <= req_nxt;
    end
  end

endmodule

/* File: bench/adm_far_side.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// jog switches and limit switch, pins pulled high when idle
// ------------------------------------------------------------
module adm_far_side
(
  // clock
  input  wire logic aclk,
  // commanded switch levels
  input  wire logic [1:0] want_plus,
  input  wire logic [1:0] want_minus,
  input  wire logic [1:0] want_limit,
  // pin levels
  output logic [1:0]      jog_plus_input = 2'b11,
  output logic [1:0]      jog_minus_input = 2'b11,
  output logic [1:0]      plus_limit_input = 2'b11
);
  always @(posedge aclk)
  begin
    jog_plus_input   <= want_plus;
    jog_minus_input  <= want_minus;
    plus_limit_input <= want_limit;
  end
endmodule

/* File: bench/adm_axis_mode_sva.sv */
`timescale 1ns/1ps
module adm_axis_mode_sva
  import adm_pkg::*;
(
  // clock and reset
  input wire logic                        aclk,
  input wire logic                        aresetn,
  // watched ports
  input wire logic [1:0]                  plus_limit_input,
  input wire logic [1:0]                  decelerating_flag,
  input wire logic [1:0][15:0]            accel_rate,
  input wire logic [1:0][15:0]            decel_rate,
  input wire logic [1:0][15:0]            ramp_rate,
  input wire logic [1:0]                  separate_decel_rate_enable,
  input wire logic [1:0]                  manual_decel_select,
  input wire logic [1:0]                  scurve_profile_select,
  input wire logic [1:0]                  triangle_avoid_enable,
  input wire logic [1:0]                  counter_wrap_enable,
  input wire logic [1:0]                  jog_cont_plus,
  input wire logic [1:0]                  jog_start_plus,
  input wire logic [1:0]                  jog_start_minus,
  input wire logic [1:0][ADM_IN_NUM-1:0]  filtered_inputs,
  input wire logic [1:0][7:0]             axis_output_pins
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_mode_clear: assert property (!$past(aresetn) |->
    {manual_decel_select, separate_decel_rate_enable, scurve_profile_select,
     triangle_avoid_enable, counter_wrap_enable} == '0)
    else $error("mode outputs not cleared");
  a_pins_clear: assert property (!$past(aresetn) |->
    axis_output_pins == '0) else $error("pins not low after reset");
  a_ramp_pick: assert property ($past(aresetn) |-> ramp_rate[1] ==
    ($past(separate_decel_rate_enable[1] && decelerating_flag[1]) ?
     $past(decel_rate[1]) : $past(accel_rate[1])))
    else $error("wrong ramp rate");
  a_cont_level: assert property (jog_cont_plus[0] |->
    !$past(filtered_inputs[0][ADM_IN_JOG_P])) else $error("cont jog high");
  a_start_edge: assert property ($past(aresetn, 2) && jog_start_plus[0] |->
    $past(filtered_inputs[0][ADM_IN_JOG_P]) !=
    $past(filtered_inputs[0][ADM_IN_JOG_P], 2)) else $error("start no edge");
  a_minus_edge: assert property ($past(aresetn, 2) && jog_start_minus[0] |->
    $past(filtered_inputs[0][8:7]) != $past(filtered_inputs[0][8:7], 2))
    else $error("minus start without edge");
  a_start_single: assert property (jog_start_plus[0] |=>
    !jog_start_plus[0]) else $error("start pulse too long");
  a_filter_src: assert property ($past(aresetn, 5) &&
    $changed(filtered_inputs[0][ADM_IN_LIM_P]) |->
    filtered_inputs[0][ADM_IN_LIM_P] == $past(plus_limit_input[0], 4))
    else $error("filtered level not from pin");
endmodule

bind adm_axis_mode adm_axis_mode_sva i_adm_axis_mode_sva (.*);

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import adm_pkg::*;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, cp, cm, lo, clr;
  logic        emergency_stop_input, emergency_filtered;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, minus_limit_input, index_stop_input, np, nm;
  logic [1:0]  in_position_input, servo_alarm_input, jog_plus_input;
  logic [1:0]  jog_minus_input, plus_limit_input, jerk_rising_flag;
  logic [1:0]  jerk_falling_flag, drive_active, accelerating_flag;
  logic [1:0]  constant_speed_flag, decelerating_flag, home_dcc_active;
  logic [1:0]  deviation_clear_output, manual_decel_select, jog_cont_plus;
  logic [1:0]  separate_decel_rate_enable, scurve_profile_select;
  logic [1:0]  triangle_avoid_enable, counter_wrap_enable, jog_cont_minus;
  logic [1:0]  jog_start_plus, jog_start_minus, want_plus, want_minus;
  logic [1:0]  want_limit;
  logic [1:0][1:0]  decel_stop_inputs;
  logic [1:0][5:0]  general_inputs;
  logic [1:0][7:0]  axis_output_pins;
  logic [1:0][15:0] accel_rate, decel_rate, ramp_rate;
  logic [1:0][31:0] logical_position, real_position;
  logic [1:0][31:0] upper_compare, lower_compare;
  logic [1:0][ADM_IN_NUM-1:0] filtered_inputs;
  int          errors, checked;

  adm_axis_mode #(.FLT_SHORT_CYC(4), .FLT_BASE_CYC(8)) i_adm_axis_mode (.*);
  adm_far_side i_adm_far_side (.*);

  always #5 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cp <= !clr & (cp | jog_cont_plus[0]);
    cm <= !clr & (cm | jog_cont_minus[0]);
    np <= clr ? 2'h0 : np + 2'(jog_start_plus[0]);
    nm <= clr ? 2'h0 : nm + 2'(jog_start_minus[0]);
    lo <= !clr & (lo | !filtered_inputs[0][ADM_IN_LIM_P]);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic [1:0] e);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {16'h0000, d};
    {awvalid, wvalid} <= 2'b11;
    do @(posedge aclk); while (!awready && ++n < 99);
    {awvalid, wvalid} <= 2'b00;
    do @(posedge aclk); while (!bvalid && ++n < 99);
    chk({30'h0, bresp}, {30'h0, e});
    chk(32'(n < 99), 32'h1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic [1:0] e);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready && ++n < 99);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid && ++n < 99);
    chk(rdata, x);
    chk(32'(n < 99), 32'h1);
    chk({30'h0, rresp}, {30'h0, e});
  endtask
  task automatic flags(input logic [5:0] a, input logic [5:0] b);
    jerk_rising_flag <= {b[0], a[0]};
    jerk_falling_flag <= {b[1], a[1]};
    drive_active <= {b[2], a[2]};
    accelerating_flag <= {b[3], a[3]};
    constant_speed_flag <= {b[4], a[4]};
    decelerating_flag <= {b[5], a[5]};
  endtask
  task automatic pins(input logic [15:0] x);
    cyc(3);
    chk({16'h0, axis_output_pins}, {16'h0, x});
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_mode;
    rd(ADM_OFS_MODE3, 32'h0, ADM_RESP_OK);
    rd(ADM_OFS_GPO, 32'h0, ADM_RESP_OK);
    pins(16'h0000);
    wr(ADM_OFS_MODE3, 16'h0065, ADM_RESP_OK);
    wr(ADM_OFS_AXIS_SEL, 16'h0001, ADM_RESP_OK);
    wr(ADM_OFS_MODE3, 16'h0002, ADM_RESP_OK);
    flags(6'h20, 6'h20);
    cyc(3);
    chk({22'h0, manual_decel_select, scurve_profile_select,
         triangle_avoid_enable, counter_wrap_enable,
         separate_decel_rate_enable}, 32'h156);
    chk(ramp_rate, {16'h4444, 16'h1111});
    flags(6'h00, 6'h00);
    cyc(3);
    chk(ramp_rate, {16'h2222, 16'h1111});
    rd(ADM_OFS_MODE3, 32'h2, ADM_RESP_OK);
  endtask
  task automatic t_pins;
    wr(ADM_OFS_GPO, 16'ha55a, ADM_RESP_OK);
    pins(16'ha55a);
    logical_position <= {32'h0, 32'h5};
    real_position <= {32'h0, 32'h2};
    upper_compare <= {32'h0, 32'h5};
    lower_compare <= {32'h0, 32'h3};
    flags(6'h15, 6'h00);
    wr(ADM_OFS_AXIS_SEL, 16'h0000, ADM_RESP_OK);
    wr(ADM_OFS_MODE3, 16'h0080, ADM_RESP_OK);
    pins(16'ha555);
    flags(6'h2a, 6'h00);
    wr(ADM_OFS_CMP_SRC, 16'h0001, ADM_RESP_OK);
    pins(16'ha5aa);
    home_dcc_active <= 2'b01;
    deviation_clear_output <= 2'b01;
    pins(16'ha5ab);
    home_dcc_active <= 2'b00;
  endtask
  task automatic t_jog;
    logic [5:0]  ex [4];
    logic [11:0] seq;
    ex = '{6'h00, 6'h30, 6'h09, 6'h05};
    seq = 12'hd21;
    for (int m = 0; m < 4; m++)
    begin
      wr(ADM_OFS_MODE3, 16'(m) << 3, ADM_RESP_OK);
      clr <= 1'b1;
      cyc(1);
      clr <= 1'b0;
      for (int s = 0; s < 6; s++)
      begin
        want_plus <= {1'b1, seq[2*s+1]};
        want_minus <= {1'b1, seq[2*s]};
        cyc(12);
      end
      chk({26'h0, cp, cm, np, nm}, {26'h0, ex[m]});
    end
  endtask
  task automatic t_filter;
    logic [15:0] md [5];
    int          gl [5];
    logic [4:0]  ex;
    md = '{16'h0000, 16'h0100, 16'h0100, 16'h2100, 16'h2100};
    gl = '{3, 2, 9, 6, 16};
    ex = 5'b10101;
    for (int i = 0; i < 5; i++)
    begin
      wr(ADM_OFS_MODE3, md[i], ADM_RESP_OK);
      clr <= 1'b1;
      cyc(1);
      clr <= 1'b0;
      want_limit <= 2'b10;
      cyc(gl[i]);
      want_limit <= 2'b11;
      cyc(30);
      chk({31'h0, lo}, {31'h0, ex[i]});
    end
    rd(ADM_OFS_STATUS, 32'h005affff, ADM_RESP_OK);
    wr(ADM_OFS_STATUS, 16'h0001, ADM_RESP_ERR);
    wr(8'h40, 16'h0001, ADM_RESP_ERR);
    rd(8'h40, 32'h0, ADM_RESP_ERR);
  endtask
  task automatic wrap_up;
    if (errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    {aclk, awvalid, wvalid, arvalid, aresetn, cp, cm, lo, clr} = '0;
    {bready, rready, emergency_stop_input} = '1;
    {awaddr, araddr, wdata, np, nm} = '0;
    wstrb = 4'h3;
    {minus_limit_input, index_stop_input, in_position_input} = '1;
    {servo_alarm_input, decel_stop_inputs, general_inputs} = '1;
    {want_plus, want_minus, want_limit} = '1;
    {home_dcc_active, deviation_clear_output} = '0;
    {accel_rate, decel_rate} = {32'h2222_1111, 32'h4444_3333};
    {logical_position, real_position, upper_compare, lower_compare} = '0;
    flags(6'h00, 6'h00);
    cyc(12);
    aresetn <= 1'b1;
    t_mode;
    t_pins;
    t_jog;
    t_filter;
    wrap_up;
  end
  initial
  begin
    #500000;
    errors++;
    wrap_up;
  end
endmodule
